// ### design/adcsq_top.sv
module adcsq_top #(
    parameter int COMB_TOTAL_US [8] = adcsq_pkg::COMB_TOTAL_US,
    parameter int SKEW_US       [8] = adcsq_pkg::SKEW_US,
    parameter int OVL_TOTAL_US  [8] = adcsq_pkg::OVL_TOTAL_US
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET_N,
    input  wire logic                    I_CMD_VALID,
    input  wire adcsq_pkg::adcsq_cmd_type I_CMD,
    input  wire logic [2:0]              I_MODE,
    input  wire logic [1:0]              I_REDUNDANCY_PATH_SELECT,
    input  wire logic [1:0]              I_SELFTEST_PATTERN_SELECT,
    input  wire logic                    I_FORCE_REDUNDANCY_FAIL,
    input  wire logic [2:0]              I_MOD_BITS,
    input  wire logic [4:0]              I_RD_ADDR,
    output logic                         O_BUSY,
    output logic                         O_DONE,
    output logic [15:0]                  O_RD_DATA
);
    import adcsq_pkg::*;

    // Whole block state
    typedef struct packed {
        adcsq_fsm_type             state;   // Sequencer state
        adcsq_cmd_type             cmd;     // Running command
        logic [2:0]                mode;    // Latched mode
        logic [1:0]                path;    // Latched path select
        logic [1:0]                stsel;   // Latched pattern select
        logic [3:0]                phase;   // Conversion phase
        logic [23:0]               timer;   // Cycles left in phase
        logic [N_ADC-1:0][15:0]    acc;     // Primary filters
        logic [15:0]               racc;    // Redundant filter
        logic [N_SLOTS-1:0][15:0]  res;     // Result slots
        logic [15:0]               rd_data; // Read port data
        logic                      done;    // Completion pulse
        logic [23:0]               run_cnt; // Cycles since start
        logic [23:0]               gap_cnt; // Cycles since cell write
    } adcsq_state_type;

    adcsq_state_type s_ff;                  // Registered state
    adcsq_state_type nxt_s;                 // Next state
    logic [N_ADC-1:0]              wr_en;   // Slot write enables
    logic [N_ADC-1:0][4:0]         wr_slot; // Slot addresses
    logic [N_ADC-1:0][15:0]        wr_data; // Slot data
    logic [1:0]                    radc;    // Checked ADC, 0 none
    logic                          phase_end; // Last cycle of phase
    logic                          last_end;  // Last cycle of command
    logic                          selftest;  // Self test running
    logic                          cell_ph;   // Cell group phase

    // Microseconds to clock cycles
    function automatic logic [23:0] cyc(input int us);
        return 24'(us * 1000 / CLK_PERIOD_NS);
    endfunction

    // Even split of a span, remainder in last phase
    function automatic logic [23:0] split(input logic [23:0] span,
                                          input logic [3:0]  n,
                                          input logic [3:0]  p);
        logic [23:0] base;
        base = span / 24'(n);
        if (p == n - 4'h1)
            return 24'(span - 28'(base) * 28'(n - 4'h1));
        return base;
    endfunction

    // Phases per command
    function automatic logic [3:0] ph_count(input adcsq_cmd_type c);
        case (c)
            CMD_CELL_STACK:  return N_COMB_PH;
            CMD_CELL_TEST:   return N_CELL_GRP;
            CMD_OVERLAP:     return N_OVL_PH;
            CMD_INT,
            CMD_INT_CHECKED: return N_STAT_PH;
            default:         return N_AUX_PH;
        endcase
    endfunction

    // Span of the cell groups of the combined command
    function automatic logic [23:0] cell_span(input logic [2:0] m);
        return cyc(COMB_TOTAL_US[m]) - cyc(SKEW_US[m]);
    endfunction

    // Length of one phase in cycles
    function automatic logic [23:0] ph_len(input adcsq_cmd_type c,
                                           input logic [2:0]    m,
                                           input logic [3:0]    p);
        case (c)
            CMD_CELL_STACK:
                if (p == N_CELL_GRP)
                    return cyc(SKEW_US[m]);
                else
                    return split(cell_span(m), N_CELL_GRP, p);
            CMD_CELL_TEST: return split(cell_span(m), N_CELL_GRP, p);
            default:       return split(cyc(OVL_TOTAL_US[m]), ph_count(c), p);
        endcase
    endfunction

    // Whole command length in cycles
    function automatic logic [23:0] cmd_total(input adcsq_cmd_type c,
                                              input logic [2:0]    m);
        case (c)
            CMD_CELL_STACK: return cyc(COMB_TOTAL_US[m]);
            CMD_CELL_TEST:  return cell_span(m);
            default:        return cyc(OVL_TOTAL_US[m]);
        endcase
    endfunction

    // Known word that the test stream decodes to
    function automatic logic [15:0] pattern(input logic [2:0] m,
                                            input logic [1:0] sel);
        if (sel == PAT_SEL_B)
            return (m == MODE_27K) ? PAT_B_27K :
                   (m == MODE_14K) ? PAT_B_14K : PAT_B_SLOW;
        return (m == MODE_27K) ? PAT_A_27K :
               (m == MODE_14K) ? PAT_A_14K : PAT_A_SLOW;
    endfunction

    // Converter watched by the redundant filter, 0 for none
    function automatic logic [1:0] red_sel(input adcsq_cmd_type c,
                                           input logic [1:0]    psel,
                                           input logic [3:0]    p);
        case (c)
            CMD_AUX, CMD_INT: return 2'h0;
            CMD_OVERLAP:
                if (p == 4'h0)
                    return (psel == 2'h3) ? 2'h0 :
                           (psel == 2'h1) ? 2'h1 : 2'h2;
                else
                    return (psel == 2'h1) ? 2'h0 :
                           (psel == 2'h3) ? 2'h3 : 2'h2;
            CMD_CELL_STACK, CMD_CELL_TEST:
                if (p < N_CELL_GRP)
                    return (psel == 2'h0) ? 2'(p % 4'h3) + 2'h1 : psel;
                else
                    return psel[1] ? 2'h0 : 2'h1;
            default: return psel[1] ? 2'h0 : 2'h1;
        endcase
    endfunction

    // Status decode of the running command
    always_comb
    begin
        selftest  = (s_ff.cmd == CMD_CELL_TEST) || (s_ff.cmd == CMD_AUX_TEST);
        cell_ph   = ((s_ff.cmd == CMD_CELL_STACK) ||
                     (s_ff.cmd == CMD_CELL_TEST)) &&
                    (s_ff.phase < N_CELL_GRP);
        radc      = red_sel(s_ff.cmd, s_ff.path, s_ff.phase);
        phase_end = (s_ff.state == FSM_RUN) && (s_ff.timer == 24'h000001);
        last_end  = phase_end && (s_ff.phase == ph_count(s_ff.cmd) - 4'h1);
    end

    // Slot map and result words of the current phase
    always_comb
    begin
        logic [15:0] prim;
        logic [15:0] red;
        logic [3:0]  nib;
        prim    = '0;
        red     = '0;
        nib     = '0;
        wr_en   = '0;
        wr_slot = '0;
        if (cell_ph)
        begin
            wr_en = 3'h7;
            for (int a = 0; a < N_ADC; a++)
                wr_slot[a] = SLOT_CELL0 + 5'(s_ff.phase) + 5'(6 * a);
        end
        else if (s_ff.cmd == CMD_OVERLAP)
        begin
            // cell 7 first, then cell 13
            if (s_ff.phase == 4'h0)
            begin
                wr_en      = 3'h3;
                wr_slot[1] = SLOT_OVL7_HI;
                wr_slot[0] = SLOT_OVL7_LO;
            end
            else
            begin
                wr_en      = 3'h6;
                wr_slot[2] = SLOT_OVL13_HI;
                wr_slot[1] = SLOT_OVL13_LO;
            end
        end
        else if (s_ff.cmd == CMD_CELL_STACK)
        begin
            wr_en[0]   = 1'b1;
            wr_slot[0] = SLOT_STAT0;
        end
        else if ((s_ff.cmd == CMD_INT) || (s_ff.cmd == CMD_INT_CHECKED))
        begin
            wr_en[0]   = 1'b1;
            wr_slot[0] = SLOT_STAT0 + 5'(s_ff.phase);
        end
        else
        begin
            wr_en[0]   = 1'b1;
            wr_slot[0] = SLOT_AUX0 + 5'(s_ff.phase);
        end
        for (int a = 0; a < N_ADC; a++)
        begin
            prim = selftest ? pattern(s_ff.mode, s_ff.stsel) : s_ff.acc[a];
            red  = selftest ? pattern(s_ff.mode, s_ff.stsel) : s_ff.racc;
            red  = red ^ {16{I_FORCE_REDUNDANCY_FAIL}};
            for (int n = 0; n < 4; n++)
                nib[n] = (prim[4*n +: 4] != red[4*n +: 4]);
            if ((radc == 2'(a + 1)) && (nib != 4'h0))
                wr_data[a] = {MISMATCH_HI, nib};
            else
                wr_data[a] = prim;
        end
    end

    // Sequencer, filters and result store
    always_comb
    begin
        nxt_s         = s_ff;
        nxt_s.done    = 1'b0;
        nxt_s.rd_data = s_ff.res[I_RD_ADDR];
        case (s_ff.state)
            FSM_IDLE:
            begin
                // Take a command only when idle
                if (I_CMD_VALID)
                begin
                    nxt_s.state   = FSM_RUN;
                    nxt_s.cmd     = I_CMD;
                    nxt_s.mode    = I_MODE;
                    nxt_s.path    = I_REDUNDANCY_PATH_SELECT;
                    nxt_s.stsel   = I_SELFTEST_PATTERN_SELECT;
                    nxt_s.phase   = 4'h0;
                    nxt_s.timer   = ph_len(I_CMD, I_MODE, 4'h0);
                    nxt_s.acc     = '0;
                    nxt_s.racc    = '0;
                    nxt_s.run_cnt = '0;
                    nxt_s.gap_cnt = '0;
                end
            end
            FSM_RUN:
            begin
                nxt_s.run_cnt = s_ff.run_cnt + 24'h000001;
                nxt_s.gap_cnt = s_ff.gap_cnt + 24'h000001;
                nxt_s.timer   = s_ff.timer - 24'h000001;
                for (int a = 0; a < N_ADC; a++)
                    if (s_ff.acc[a] != RESULT_RST)
                        nxt_s.acc[a] = s_ff.acc[a] + 16'(I_MOD_BITS[a]);
                if ((radc != 2'h0) && (s_ff.racc != RESULT_RST))
                    nxt_s.racc = s_ff.racc + 16'(I_MOD_BITS[radc - 2'h1]);
                if (phase_end)
                begin
                    for (int a = 0; a < N_ADC; a++)
                        if (wr_en[a])
                            nxt_s.res[wr_slot[a]] = wr_data[a];
                    if (cell_ph)
                        nxt_s.gap_cnt = '0;
                    nxt_s.acc   = '0;
                    nxt_s.racc  = '0;
                    nxt_s.phase = s_ff.phase + 4'h1;
                    nxt_s.timer = ph_len(s_ff.cmd, s_ff.mode,
                                         s_ff.phase + 4'h1);
                    if (last_end)
                    begin
                        nxt_s.state = FSM_IDLE;
                        nxt_s.done  = 1'b1;
                    end
                end
            end
            default: nxt_s.state = FSM_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            s_ff       <= '0;
            s_ff.res   <= {N_SLOTS{RESULT_RST}};
            s_ff.state <= FSM_IDLE;
        end
        else
            s_ff <= nxt_s;
    end

    // Outputs
    assign O_BUSY    = (s_ff.state != FSM_IDLE);
    assign O_DONE    = s_ff.done;
    assign O_RD_DATA = s_ff.rd_data;

    // Checks
    localparam int SKEW_FAST_CYC = SKEW_US[0] * 1000 / CLK_PERIOD_NS;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    property p_total_time;
        last_end |-> (s_ff.run_cnt + 24'h000001 ==
                      cmd_total(s_ff.cmd, s_ff.mode)) ##1 O_DONE ##1 !O_DONE;
    endproperty
    a_total_time: assert property (p_total_time)
        else $error("command length differs from mode table");
    property p_skew_fast;
        (s_ff.cmd == CMD_CELL_STACK) && (s_ff.mode == MODE_27K) &&
        phase_end && !cell_ph |-> (32'(s_ff.gap_cnt) < SKEW_FAST_CYC);
    endproperty
    a_skew_fast: assert property (p_skew_fast)
        else $error("cell to stack skew too long");
    property p_cells_all;
        phase_end && cell_ph |-> (wr_en == 3'h7) &&
            (wr_slot[2] == wr_slot[0] + 5'h0C);
    endproperty
    a_cells_all: assert property (p_cells_all)
        else $error("cell group not written on all converters");
    property p_sum_slot;
        phase_end && (s_ff.cmd == CMD_CELL_STACK) && !cell_ph |->
            last_end && (wr_slot[0] == SLOT_STAT0);
    endproperty
    a_sum_slot: assert property (p_sum_slot)
        else $error("stack sum not last or in wrong slot");
    property p_path_forced;
        (s_ff.state == FSM_RUN) && cell_ph && (s_ff.path != 2'h0) |->
            (radc == s_ff.path);
    endproperty
    a_path_forced: assert property (p_path_forced)
        else $error("forced path not honoured");
    property p_no_check;
        (s_ff.state == FSM_RUN) && ((s_ff.cmd == CMD_AUX) ||
        (s_ff.cmd == CMD_INT) || (s_ff.path[1] && !cell_ph &&
        (s_ff.cmd != CMD_OVERLAP))) |-> (radc == 2'h0);
    endproperty
    a_no_check: assert property (p_no_check)
        else $error("check applied where none is allowed");
    property p_ovl_first;
        (s_ff.cmd == CMD_OVERLAP) && phase_end && (s_ff.phase == 4'h0)
        |=> (s_ff.res[SLOT_OVL7_HI] == $past(wr_data[1])) &&
            (s_ff.res[SLOT_OVL7_LO] == $past(wr_data[0]));
    endproperty
    a_ovl_first: assert property (p_ovl_first)
        else $error("cell 7 overlap results misplaced");
    property p_force_fail;
        phase_end && (radc != 2'h0) && I_FORCE_REDUNDANCY_FAIL |->
            (wr_data[radc - 2'h1] == {MISMATCH_HI, 4'hF});
    endproperty
    a_force_fail: assert property (p_force_fail)
        else $error("forced failure not reported");
    property p_pattern;
        selftest && phase_end && !I_FORCE_REDUNDANCY_FAIL |->
            (wr_data[0] == pattern(s_ff.mode, s_ff.stsel));
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("self test word wrong");
    c_comb: cover property (last_end && (s_ff.cmd == CMD_CELL_STACK));
    c_ovl: cover property (last_end && (s_ff.cmd == CMD_OVERLAP));
    c_test: cover property (last_end && selftest);
    c_fail: cover property (phase_end && (radc != 2'h0) &&
                            I_FORCE_REDUNDANCY_FAIL);
endmodule

// ### include/adcsq_pkg.sv
package adcsq_pkg;
    // Clock period in ns
    localparam int          CLK_PERIOD_NS = 40;
    // Number of conversion modes, slots and converters
    localparam int          N_MODES       = 8;
    localparam int          N_SLOTS       = 32;
    localparam int          N_ADC         = 3;
    // Mode indices of the two fastest modes
    localparam logic [2:0]  MODE_27K      = 3'h0;
    localparam logic [2:0]  MODE_14K      = 3'h1;
    // Phase counts per command family
    localparam logic [3:0]  N_CELL_GRP    = 4'h6;
    localparam logic [3:0]  N_COMB_PH     = 4'h7;
    localparam logic [3:0]  N_OVL_PH      = 4'h2;
    localparam logic [3:0]  N_AUX_PH      = 4'hA;
    localparam logic [3:0]  N_STAT_PH     = 4'h4;
    // Result slot map
    localparam logic [4:0]  SLOT_CELL0    = 5'h00;
    localparam logic [4:0]  SLOT_OVL7_HI  = 5'h06;
    localparam logic [4:0]  SLOT_OVL7_LO  = 5'h07;
    localparam logic [4:0]  SLOT_OVL13_HI = 5'h0C;
    localparam logic [4:0]  SLOT_OVL13_LO = 5'h0D;
    localparam logic [4:0]  SLOT_AUX0     = 5'h12;
    localparam logic [4:0]  SLOT_STAT0    = 5'h1C;
    // Result reset value and mismatch marker
    localparam logic [15:0] RESULT_RST    = 16'hFFFF;
    localparam logic [11:0] MISMATCH_HI   = 12'hFF0;
    // Self test patterns
    localparam logic [15:0] PAT_A_27K     = 16'h9565;
    localparam logic [15:0] PAT_A_14K     = 16'h9553;
    localparam logic [15:0] PAT_A_SLOW    = 16'h9555;
    localparam logic [15:0] PAT_B_27K     = 16'h6A9A;
    localparam logic [15:0] PAT_B_14K     = 16'h6AAC;
    localparam logic [15:0] PAT_B_SLOW    = 16'h6AAA;
    localparam logic [1:0]  PAT_SEL_B     = 2'h2;
    // Durations in microseconds, fastest mode first
    localparam int COMB_TOTAL_US [N_MODES] =
        '{1331, 1534, 2756, 3571, 5200, 8458, 14974, 234902};
    localparam int SKEW_US [N_MODES] =
        '{147, 235, 409, 758, 1456, 2853, 5645, 89427};
    localparam int OVL_TOTAL_US [N_MODES] =
        '{384, 442, 791, 1024, 1490, 2420, 4282, 67119};
    // Command codes
    typedef enum logic [2:0] {
        CMD_CELL_STACK   = 3'h0,
        CMD_OVERLAP      = 3'h1,
        CMD_CELL_TEST    = 3'h2,
        CMD_AUX_TEST     = 3'h3,
        CMD_AUX          = 3'h4,
        CMD_AUX_CHECKED  = 3'h5,
        CMD_INT          = 3'h6,
        CMD_INT_CHECKED  = 3'h7
    } adcsq_cmd_type;
    // Sequencer states
    typedef enum logic [1:0] {
        FSM_IDLE = 2'h0,
        FSM_RUN  = 2'h1
    } adcsq_fsm_type;
endpackage

// ### verif/adcsq_mod_model.sv
module adcsq_mod_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic [2:0] i_level,
    output logic      [2:0] o_mod_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // Modulator front end, one stream bit per converter
    // one-bit stream per converter
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        // Quiet stream while in reset
        if (!i_reset_n)
            o_mod_bits <= 3'h0;
        // Steady density chosen by the bench
        else
            o_mod_bits <= i_level;
    end
endmodule

// ### verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsq_pkg::*;
    // Short duration tables in us, fast modes differ
    localparam int COMB [8] = '{12, 16, 20, 20, 20, 20, 20, 20};
    localparam int SKEW [8] = '{2, 3, 4, 4, 4, 4, 4, 4};
    localparam int OVL  [8] = '{10, 12, 14, 14, 14, 14, 14, 14};
    logic          clk = 1'b0;  // Bench clock
    logic          rst_n;       // Reset, active low
    logic          cmd_valid;   // Command request
    adcsq_cmd_type cmd;         // Command code
    logic [2:0]    mode;        // Conversion mode
    logic [1:0]    path_sel;    // Path select
    logic [1:0]    pat_sel;     // Pattern select
    logic          force_fail;  // Forced check failure
    logic [2:0]    level;       // Modulator levels
    logic [2:0]    mod_bits;    // Stream into filters
    logic [4:0]    rd_addr;     // Result slot index
    logic          busy;        // Command running
    logic          done;        // Completion pulse
    logic [15:0]   rd_data;     // Result word
    int            num_errors;  // Mismatch count
    int            checks_done; // Comparison count
    // Device under test
    adcsq_top #(.COMB_TOTAL_US(COMB), .SKEW_US(SKEW), .OVL_TOTAL_US(OVL))
    u_adcsq_top (.I_CLK(clk), .I_RESET_N(rst_n), .I_CMD_VALID(cmd_valid),
        .I_CMD(cmd), .I_MODE(mode), .I_REDUNDANCY_PATH_SELECT(path_sel),
        .I_SELFTEST_PATTERN_SELECT(pat_sel),
        .I_FORCE_REDUNDANCY_FAIL(force_fail),
        .I_MOD_BITS(mod_bits), .I_RD_ADDR(rd_addr), .O_BUSY(busy),
        .O_DONE(done), .O_RD_DATA(rd_data));
    // Modulator model
    adcsq_mod_model u_adcsq_mod_model (.i_clk(clk), .i_reset_n(rst_n),
        .i_level(level), .o_mod_bits(mod_bits));
    // Clock, 40 ns period
    always #20 clk = ~clk;
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Issue one command, time it to completion
    task automatic run(input adcsq_cmd_type c, input logic [2:0] m,
                       input logic [1:0] p, input logic [1:0] s, input int n);
        int k;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        mode <= m;
        path_sel <= p;
        pat_sel <= s;
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        check(busy, 1'b1);
        k = 1;
        while (done !== 1'b1 && k < 20000)
        begin
            @(negedge clk);
            k++;
        end
        check(k, n + 1);
        check(busy, 1'b0);
    endtask
    // Read one slot, only after completion
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        @(negedge clk);
        check(rd_data, exp);
    endtask
    // Expected self test word
    function automatic logic [15:0] pat(input logic [2:0] m,
                                        input logic [1:0] s);
        if (s == PAT_SEL_B)
            return m == MODE_27K ? PAT_B_27K :
                   m == MODE_14K ? PAT_B_14K : PAT_B_SLOW;
        return m == MODE_27K ? PAT_A_27K :
               m == MODE_14K ? PAT_A_14K : PAT_A_SLOW;
    endfunction
    // Reset values of slots
    task automatic t_reset();
        check(busy, 1'b0);
        rd(5'h00, RESULT_RST);
        rd(5'h1F, RESULT_RST);
        $display("t_reset done");
    endtask
    // Combined cells and stack, two modes
    task automatic t_comb();
        int gl;
        int cl;
        for (int m = 0; m < 2; m++)
        begin
            cl = (COMB[m] - SKEW[m]) * 25;
            gl = cl / 6;
            run(CMD_CELL_STACK, 3'(m), 2'h0, 2'h1, COMB[m] * 25);
            rd(5'h00, 16'(gl - 1));
            rd(5'h11, 16'(cl - 5 * gl - 1));
            rd(5'h1C, 16'(SKEW[m] * 25 - 1));
        end
        $display("t_comb done");
    endtask
    // Overlap cells, converter two held low
    task automatic t_overlap();
        int h;
        @(posedge clk);
        level <= 3'h5;
        for (int m = 0; m < 2; m++)
        begin
            h = OVL[m] * 25 / 2;
            run(CMD_OVERLAP, 3'(m), 2'h0, 2'h1, OVL[m] * 25);
            rd(SLOT_OVL7_HI, 16'h0000);
            rd(SLOT_OVL7_LO, 16'(h - 1));
            rd(SLOT_OVL13_HI, 16'(OVL[m] * 25 - h - 1));
            rd(SLOT_OVL13_LO, 16'h0000);
        end
        @(posedge clk);
        level <= 3'h7;
        $display("t_overlap done");
    endtask
    // Self test patterns over modes and options
    task automatic t_selftest();
        logic [15:0] e;
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 3; s++)
            begin
                e = pat(3'(m), 2'(s));
                run(CMD_CELL_TEST, 3'(m), 2'h0, 2'(s),
                    (COMB[m] - SKEW[m]) * 25);
                rd(5'h11, e);
                run(CMD_AUX_TEST, 3'(m), 2'h0, 2'(s), OVL[m] * 25);
                rd(5'h00, e);
                rd(5'h12, e);
                rd(5'h1B, e);
                rd(5'h1C, 16'(SKEW[1] * 25 - 1));
            end
        $display("t_selftest done");
    endtask
    // Forced check failure on checked paths
    task automatic t_force();
        logic [4:0]  sl [6];
        logic [5:0]  msk [4];
        logic [15:0] e;
        int          gl;
        gl = (COMB[0] - SKEW[0]) * 25 / 6;
        sl = '{5'h00, 5'h01, 5'h07, 5'h0C, 5'h0E, 5'h1C};
        msk = '{6'h2B, 6'h31, 6'h08, 6'h06};
        @(posedge clk);
        force_fail <= 1'b1;
        run(CMD_AUX_CHECKED, 3'h0, 2'h0, 2'h1, OVL[0] * 25);
        rd(5'h12, 16'hFF0F);
        rd(5'h1B, 16'hFF0F);
        run(CMD_AUX, 3'h0, 2'h0, 2'h1, OVL[0] * 25);
        rd(5'h12, 16'(OVL[0] * 25 / 10 - 1));
        run(CMD_AUX_CHECKED, 3'h0, 2'h2, 2'h1, OVL[0] * 25);
        rd(5'h1B, 16'(OVL[0] * 25 / 10 - 1));
        run(CMD_INT_CHECKED, 3'h0, 2'h1, 2'h1, OVL[0] * 25);
        rd(5'h1C, 16'hFF0F);
        run(CMD_INT, 3'h0, 2'h0, 2'h1, OVL[0] * 25);
        rd(5'h1C, 16'(OVL[0] * 25 / 4 - 1));
        rd(5'h1F, 16'(OVL[0] * 25 - 3 * (OVL[0] * 25 / 4) - 1));
        // Path 11: cell 7 unchecked, cell 13 checked on converter three
        run(CMD_OVERLAP, 3'h0, 2'h3, 2'h1, OVL[0] * 25);
        rd(SLOT_OVL7_HI, 16'(OVL[0] * 25 / 2 - 1));
        rd(SLOT_OVL13_HI, 16'hFF0F);
        rd(SLOT_OVL13_LO, 16'(OVL[0] * 25 / 2 - 1));
        for (int p = 0; p < 4; p++)
        begin
            run(CMD_CELL_STACK, 3'h0, 2'(p), 2'h1, COMB[0] * 25);
            for (int i = 0; i < 6; i++)
            begin
                e = msk[p][5 - i] ? 16'hFF0F :
                    i == 5 ? 16'(SKEW[0] * 25 - 1) : 16'(gl - 1);
                rd(sl[i], e);
            end
        end
        @(posedge clk);
        force_fail <= 1'b0;
        run(CMD_AUX_CHECKED, 3'h0, 2'h0, 2'h1, OVL[0] * 25);
        rd(5'h12, 16'(OVL[0] * 25 / 10 - 1));
        $display("t_force done");
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        #(40000 * 40);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = CMD_CELL_STACK;
        mode = 3'h0;
        path_sel = 2'h0;
        pat_sel = 2'h1;
        force_fail = 1'b0;
        level = 3'h7;
        rd_addr = 5'h00;
        num_errors = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_comb();
        t_overlap();
        t_selftest();
        t_force();
        results();
    end
endmodule
